// *** hw/hdrc_pkg.sv ***
// hdrc_pkg: constants shared by the hdr compander / exposure limiter block
// assumes: 32-bit axi4-lite register bus, 12-bit long and short exposure pixels
package hdrc_pkg;

   // register byte offsets
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;   // control: compand, hdr, ratio, motion
   localparam logic [7:0]  ADDR_FRAME_LEN  = 8'h04;   // frame length in rows
   localparam logic [7:0]  ADDR_COARSE     = 8'h08;   // requested long-exposure rows
   localparam logic [7:0]  ADDR_LIMITS     = 8'h0C;   // {max rows, applied rows}
   localparam logic [7:0]  ADDR_STATUS     = 8'h10;   // {over cap, short rows}
   localparam logic [7:0]  ADDR_MOTION     = 8'h14;   // motion-corrected pixel count

   // control field positions
   localparam int          CTRL_COMPAND_BIT = 0;
   localparam int          CTRL_HDR_BIT     = 1;
   localparam int          CTRL_RATIO_LSB   = 2;      // two-bit exposure_ratio_sel
   localparam int          CTRL_MOTION_BIT  = 14;
   localparam int          STATUS_CAP_BIT   = 16;
   localparam logic [15:0] CTRL_WMASK       = 16'h400F;

   // reset values: hdr on, 16x ratio, companding off
   localparam logic [15:0] CTRL_RESET      = 16'h000A;
   localparam logic [15:0] FRAME_LEN_RESET = 16'h0400;
   localparam logic [15:0] COARSE_RESET    = 16'h0200;

   // exposure ratio encodings
   localparam logic [1:0]  RATIO_4X  = 2'h0;
   localparam logic [1:0]  RATIO_8X  = 2'h1;
   localparam logic [1:0]  RATIO_16X = 2'h2;
   localparam logic [1:0]  RATIO_32X = 2'h3;

   // row limits
   localparam logic [15:0] LINE_BUFFERS    = 16'h0046; // 70 intermediate line buffers
   localparam logic [15:0] HDR_ROW_MARGIN  = 16'h0047; // 71
   localparam logic [15:0] LIN_ROW_MARGIN  = 16'h0001;
   localparam logic [15:0] EFF_RECIP_70    = 16'h03A9; // 16/70 scaled by 4096
   localparam int          EFF_RECIP_SHIFT = 12;
   localparam int          EFF_FRAC        = 4;        // ratio carried with 4 fraction bits

   // compander knees, bases and segment shifts
   localparam logic [15:0] KNEE1  = 16'h0400;
   localparam logic [15:0] KNEE2  = 16'h1000;
   localparam logic [15:0] KNEE3  = 16'h8000;
   localparam logic [11:0] BASE2  = 12'h400;
   localparam logic [11:0] BASE3  = 12'hA00;
   localparam logic [11:0] BASE4  = 12'hD80;
   localparam int          SHIFT2 = 1;
   localparam int          SHIFT3 = 5;
   localparam int          SHIFT4 = 6;
   localparam logic [11:0] CODE_MAX = 12'hF7F;

   // pixel path
   localparam logic [11:0] SAT_LEVEL     = 12'hF00;  // long pixel treated as clipped
   localparam logic [15:0] MOTION_THRESH = 16'h0100;
   localparam int          PIX_W         = 16;
   localparam int          FIFO_DEPTH    = 32;
   localparam int          FIFO_MARGIN   = 3;

   // axi responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : hdrc_pkg

// *** hw/hdrc_compander.sv ***
// hdrc_compander: fixed four-segment 16-to-12 bit compander, purely combinational
// assumes: input already shifted to the 16-bit range by the caller
`timescale 1ns/10ps
module hdrc_compander
   import hdrc_pkg::*;
(
   // linear value in
   input  wire logic [15:0] lin_in,
   // compressed code out
   output logic      [11:0] code_out
);

   // each segment divides by a power of two, so truncation is a shift
   always_comb begin
      if (lin_in < KNEE1) begin
         code_out = lin_in[11:0];
      end else if (lin_in < KNEE2) begin
         code_out = BASE2 + 12'(16'(lin_in - KNEE1) >> SHIFT2);
      end else if (lin_in < KNEE3) begin
         code_out = BASE3 + 12'(16'(lin_in - KNEE2) >> SHIFT3);
      end else begin
         code_out = BASE4 + 12'(16'(lin_in - KNEE3) >> SHIFT4);
      end
   end

endmodule : hdrc_compander

// *** hw/hdrc_fifo.sv ***
// hdrc_fifo: flip-flop fifo with valid/ready on both sides
// assumes: one clock, reset already synchronised by the caller
`timescale 1ns/10ps
module hdrc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // fill side
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   // drain side
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   // occupancy
   output logic [$clog2(DEPTH+1)-1:0]      count
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage words
      logic [PW-1:0]               wr_idx;
      logic [PW-1:0]               rd_idx;
      logic [CW-1:0]               count;
   } hdrc_fifo_s;

   hdrc_fifo_s st_reg;                    // registered state
   hdrc_fifo_s st_next;                   // next state
   logic       push;                      // word enters
   logic       pop;                       // word leaves

   assign in_ready  = (st_reg.count != CW'(DEPTH));
   assign out_valid = (st_reg.count != '0);
   assign out_data  = st_reg.mem[st_reg.rd_idx];
   assign count     = st_reg.count;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer wrap relies on a power-of-two depth
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wr_idx] = in_data;
         st_next.wr_idx             = st_reg.wr_idx + PW'(1);
      end
      if (pop) begin
         st_next.rd_idx = st_reg.rd_idx + PW'(1);
      end
      st_next.count = st_reg.count + CW'(push) - CW'(pop);
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

endmodule : hdrc_fifo

// *** hw/hdrc_top.sv ***
// hdrc_top: hdr merge, ratio shift, compander, exposure row limiter, axi4-lite registers
// assumes: pixels from the exposure combiner on clk; isp drains with valid/ready
//
// Contract
// - merge long and short into 16-bit linear
// - compand enable reduces pixel to 12 bits; code compands only with hdr on, linear mode passes the 16-bit word
// - 0-1023 pass; 1024-4095 halved above 1024
// - 4096-32767 divided by 32 plus 2560
// - 32768-65535 divided by 64 plus 3456
// - shift merged data to 16 bits before compander
// - ratio field value 2 selects 16x
// - 70 line buffers cap long rows
// - over cap: short held 70, effective ratio
// - max long rows: frame minus 71 or 1
// - minimum rows: one linear, half ratio hdr
// - control bit 14 enables motion correction
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module hdrc_top
   import hdrc_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // axi4-lite write address / data / response
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // pixel pairs from the exposure combiner
   input  wire logic        pix_valid,
   output logic             pix_ready,
   input  wire logic [11:0] long_exposure,
   input  wire logic [11:0] short_exposure,
   // pixel stream to the isp
   output logic             isp_valid,
   input  wire logic        isp_ready,
   output logic [15:0]      isp_data
);
   localparam int CW = $clog2(FIFO_DEPTH+1);

   typedef struct packed {
      logic        awready, wready, aw_held, w_held, bvalid, arready, rvalid;
      logic [7:0]  aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic [1:0]  bresp, rresp;
      logic [31:0] rdata;
      logic [15:0] ctrl, frame_len, coarse;          // software settings
      logic [15:0] applied_long, max_long, short_rows, eff_q4, motion_cnt;
      logic        over_cap;                         // long rows past buffer cap
      logic        in_ready, s1_valid;
      logic [15:0] s1_data;                          // shifted linear pixel
      logic        out_valid;
      logic [15:0] out_data;
   } hdrc_state_s;

   localparam hdrc_state_s ST_RESET = '{ctrl: CTRL_RESET, frame_len: FRAME_LEN_RESET,
                                        coarse: COARSE_RESET, default: '0};

   logic              rst_meta_n, rst_sync_n;       // reset release synchroniser
   hdrc_state_s       st_reg, st_next;              // block state apart from the fifo and the reset synchroniser
   logic              hdr_c, comp_c, motion_en_c;   // decoded control bits
   logic [1:0]        ratio_sel;                    // exposure_ratio_sel
   logic [2:0]        ratio_log2;
   logic [15:0]       ratio_c, cap_c, frame_hdr_c, frame_lin_c, min_c, lim_c, applied_c;
   logic              over_cap_c;
   logic              accept;                       // pixel pair taken
   logic              sat_c, motion_hit;
   logic [23:0]       long24, scaled24, merged24, shifted24, diff24;
   logic [15:0]       lin16;
   logic [11:0]       code;                         // compander output
   logic              fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [15:0]       fifo_in_data, fifo_out_data;
   logic [CW-1:0]     fifo_count;
   logic [31:0]       wr_full;                      // strobe-merged write word

   // reset is asserted at once and released two edges later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // control decode
   assign hdr_c       = st_reg.ctrl[CTRL_HDR_BIT];
   assign comp_c      = st_reg.ctrl[CTRL_COMPAND_BIT];
   assign motion_en_c = st_reg.ctrl[CTRL_MOTION_BIT];
   assign ratio_sel   = st_reg.ctrl[CTRL_RATIO_LSB +: 2];
   assign ratio_log2  = 3'(ratio_sel) + 3'h2;
   assign ratio_c     = 16'h0001 << ratio_log2;
   assign accept      = pix_valid && st_reg.in_ready;

   // exposure row limits, recomputed every cycle from the settings
   always_comb begin
      cap_c       = LINE_BUFFERS << ratio_log2;
      frame_hdr_c = (st_reg.frame_len > HDR_ROW_MARGIN) ?
                    st_reg.frame_len - HDR_ROW_MARGIN : 16'h0000;
      frame_lin_c = (st_reg.frame_len > LIN_ROW_MARGIN) ?
                    st_reg.frame_len - LIN_ROW_MARGIN : 16'h0000;
      min_c       = hdr_c ? (ratio_c >> 1) : 16'h0001;
      lim_c       = hdr_c ? frame_hdr_c : frame_lin_c;
      // the lower bound wins when a short frame leaves no legal range
      applied_c   = (st_reg.coarse > lim_c) ? lim_c : st_reg.coarse;
      if (applied_c < min_c) begin
         applied_c = min_c;
      end
      over_cap_c  = hdr_c && (applied_c > cap_c);
   end

   // pixel merge: clipped long pixels and motion regions take the scaled short pixel
   always_comb begin
      long24    = 24'(long_exposure);
      scaled24  = 24'((28'(short_exposure) * 28'(st_reg.eff_q4)) >> EFF_FRAC);
      sat_c     = long_exposure >= SAT_LEVEL;
      diff24    = (long24 > scaled24) ? long24 - scaled24 : scaled24 - long24;
      motion_hit = hdr_c && motion_en_c && !sat_c && (diff24 > 24'(MOTION_THRESH));
      merged24  = (sat_c || motion_hit) ? scaled24 : long24;
      // the shift follows the programmed ratio even past the cap
      unique case (ratio_sel)
         RATIO_4X:  shifted24 = merged24 << 2;
         RATIO_8X:  shifted24 = merged24 << 1;
         RATIO_16X: shifted24 = merged24;
         RATIO_32X: shifted24 = merged24 >> 1;
      endcase
      // clip rather than wrap if a long exposure overshoots the range
      lin16 = (shifted24[23:16] != 8'h00) ? 16'hFFFF : shifted24[15:0];
   end

   hdrc_compander u_compander (
      .lin_in   (st_reg.s1_data),
      .code_out (code)
   );

   // 12-bit code only in hdr with companding on; otherwise the linear word
   assign fifo_in_data   = (hdr_c && comp_c) ? {4'h0, code} : st_reg.s1_data;
   assign fifo_out_ready = !st_reg.out_valid || isp_ready;

   hdrc_fifo #(
      .WIDTH (PIX_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_sync_n),
      .in_valid  (st_reg.s1_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data),
      .count     (fifo_count)
   );

   // byte-lane merge of the held write data into the addressed register
   always_comb begin
      wr_full = 32'h0000_0000;
      unique case (st_reg.aw_addr)
         ADDR_CTRL:      wr_full = {16'h0000, st_reg.ctrl};
         ADDR_FRAME_LEN: wr_full = {16'h0000, st_reg.frame_len};
         ADDR_COARSE:    wr_full = {16'h0000, st_reg.coarse};
         default:        wr_full = 32'h0000_0000;
      endcase
      for (int b = 0; b < 4; b++) begin
         if (st_reg.w_strb[b]) begin
            wr_full[8*b +: 8] = st_reg.w_data[8*b +: 8];
         end
      end
   end

   // next state of the block, apart from the fifo and the reset synchroniser
   always_comb begin
      st_next = st_reg;
      // write channel: address and data held in either order
      st_next.awready = !st_reg.aw_held && !st_reg.bvalid;
      st_next.wready  = !st_reg.w_held && !st_reg.bvalid;
      if (s_axi_awvalid && st_reg.awready) begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
         st_next.awready = 1'b0;
      end
      if (s_axi_wvalid && st_reg.wready) begin
         st_next.w_held = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
         st_next.wready = 1'b0;
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
         st_next.aw_held = 1'b0;
         st_next.w_held  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = RESP_OKAY;
         unique case (st_reg.aw_addr)
            ADDR_CTRL:      st_next.ctrl      = wr_full[15:0] & CTRL_WMASK;
            ADDR_FRAME_LEN: st_next.frame_len = wr_full[15:0];
            ADDR_COARSE:    st_next.coarse    = wr_full[15:0];
            ADDR_LIMITS, ADDR_STATUS, ADDR_MOTION: st_next.bresp = RESP_OKAY;
            default:        st_next.bresp = RESP_SLVERR;
         endcase
      end
      // read channel: one outstanding read, data one edge after the address
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.rresp  = RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_CTRL:      st_next.rdata = {16'h0000, st_reg.ctrl};
            ADDR_FRAME_LEN: st_next.rdata = {16'h0000, st_reg.frame_len};
            ADDR_COARSE:    st_next.rdata = {16'h0000, st_reg.coarse};
            ADDR_LIMITS:    st_next.rdata = {st_reg.max_long, st_reg.applied_long};
            ADDR_STATUS:    st_next.rdata = {15'h0000, st_reg.over_cap, st_reg.short_rows};
            ADDR_MOTION:    st_next.rdata = {16'h0000, st_reg.motion_cnt};
            default: begin
               st_next.rdata = 32'h0000_0000;
               st_next.rresp = RESP_SLVERR;
            end
         endcase
      end
      st_next.arready = !st_next.rvalid;
      // exposure results
      st_next.applied_long = applied_c;
      st_next.max_long     = hdr_c ? ((cap_c < frame_hdr_c) ? cap_c : frame_hdr_c)
                                   : frame_lin_c;
      st_next.over_cap     = over_cap_c;
      st_next.short_rows   = over_cap_c ? LINE_BUFFERS : (applied_c >> ratio_log2);
      st_next.eff_q4       = over_cap_c ?
                             16'((32'(applied_c) * 32'(EFF_RECIP_70)) >> EFF_RECIP_SHIFT) :
                             (ratio_c << EFF_FRAC);
      // pixel stage: margin covers the stage and a pair already in flight
      st_next.in_ready = (32'(fifo_count) + FIFO_MARGIN <= FIFO_DEPTH);
      st_next.s1_valid = accept;
      if (accept) begin
         st_next.s1_data = hdr_c ? lin16 : {4'h0, long_exposure};
         if (motion_hit) begin
            st_next.motion_cnt = st_reg.motion_cnt + 16'h0001;
         end
      end
      // output register in front of the isp
      if (fifo_out_ready) begin
         st_next.out_valid = fifo_out_valid;
         st_next.out_data  = fifo_out_data;
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flip-flops
   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready  = st_reg.wready;
   assign s_axi_bvalid  = st_reg.bvalid;
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid  = st_reg.rvalid;
   assign s_axi_rdata   = st_reg.rdata;
   assign s_axi_rresp   = st_reg.rresp;
   assign pix_ready     = st_reg.in_ready;
   assign isp_valid     = st_reg.out_valid;
   assign isp_data      = st_reg.out_data;

   // checks on the pixel path and the row limiter
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_n);

   property p_fifo_room;
      st_reg.s1_valid |-> fifo_in_ready;
   endproperty
   a_fifo_room: assert property (p_fifo_room) else $error("pixel stage met a full fifo");

   property p_merge_short;
      accept && hdr_c && sat_c && ratio_sel == RATIO_16X && st_reg.eff_q4 == 16'h0100
      |=> st_reg.s1_data == {$past(short_exposure), 4'h0};
   endproperty
   a_merge_short: assert property (p_merge_short) else $error("clipped pixel not rebuilt");

   property p_narrow;
      st_reg.s1_valid && hdr_c && comp_c |-> fifo_in_data[15:12] == 4'h0;
   endproperty
   a_narrow: assert property (p_narrow) else $error("companded word wider than 12 bits");

   property p_seg1;
      st_reg.s1_data < KNEE1 |-> code == st_reg.s1_data[11:0];
   endproperty
   a_seg1: assert property (p_seg1) else $error("low segment altered");

   property p_seg2;
      st_reg.s1_data >= KNEE1 && st_reg.s1_data < KNEE2
      |-> code == 12'(((st_reg.s1_data - 16'h0400) >> 1) + 16'h0400);
   endproperty
   a_seg2: assert property (p_seg2) else $error("second segment wrong");

   property p_seg3;
      st_reg.s1_data >= KNEE2 && st_reg.s1_data < KNEE3
      |-> code == 12'(((st_reg.s1_data - 16'h1000) >> 5) + 16'h0A00);
   endproperty
   a_seg3: assert property (p_seg3) else $error("third segment wrong");

   property p_seg4;
      st_reg.s1_data >= KNEE3
      |-> code == 12'(((st_reg.s1_data - 16'h8000) >> 6) + 16'h0D80) && code <= CODE_MAX;
   endproperty
   a_seg4: assert property (p_seg4) else $error("top segment wrong");

   property p_shift4x;
      accept && hdr_c && ratio_sel == RATIO_4X && !sat_c && !motion_hit
      |=> st_reg.s1_data == {2'h0, $past(long_exposure), 2'h0};
   endproperty
   a_shift4x: assert property (p_shift4x) else $error("4x data not shifted up by two");

   // the edge that lifts reset still leaves st_reg at its reset value, so skip it
   property p_ratio16;
      rst_sync_n && ratio_sel == RATIO_16X && !over_cap_c |=> st_reg.eff_q4 == 16'h0100;
   endproperty
   a_ratio16: assert property (p_ratio16) else $error("ratio code 2 is not 16x");

   property p_under_cap;
      rst_sync_n && hdr_c && !over_cap_c
      |=> st_reg.short_rows == ($past(applied_c) >> $past(ratio_log2));
   endproperty
   a_under_cap: assert property (p_under_cap) else $error("short rows not long over ratio");

   property p_over_cap;
      over_cap_c |=> st_reg.over_cap && st_reg.short_rows == 16'h0046;
   endproperty
   a_over_cap: assert property (p_over_cap) else $error("short rows not held at 70");

   property p_max_rows;
      hdr_c && st_reg.frame_len > HDR_ROW_MARGIN
      |=> st_reg.max_long + 16'h0047 <= $past(st_reg.frame_len) && st_reg.max_long <= $past(cap_c);
   endproperty
   a_max_rows: assert property (p_max_rows) else $error("row maximum too large");

   property p_min_rows;
      rst_sync_n && hdr_c |=> st_reg.applied_long >= ($past(ratio_c) >> 1);
   endproperty
   a_min_rows: assert property (p_min_rows) else $error("rows below half the ratio");

   property p_motion_off;
      !motion_en_c |=> st_reg.motion_cnt == $past(st_reg.motion_cnt);
   endproperty
   a_motion_off: assert property (p_motion_off) else $error("motion fix while disabled");

   c_top_segment: cover property (st_reg.s1_valid && comp_c && st_reg.s1_data >= KNEE3);
   c_over_cap:    cover property (st_reg.over_cap);
   c_backpress:   cover property (!st_reg.in_ready && pix_valid);
   c_axi_write:   cover property (st_reg.bvalid && s_axi_bready);

endmodule : hdrc_top

// *** verification/hdrc_isp_model.sv ***
// isp stand-in that drains the pixel stream and keeps every word
// assumes: shares clk with the block; the bench sets the stall pattern
`timescale 1ns/10ps
module hdrc_isp_model
   import hdrc_pkg::*;
(
   // clock
   input  wire logic        clk,
   // stream from the block
   input  wire logic        isp_valid,
   output logic             isp_ready,
   input  wire logic [15:0] isp_data,
   // bench control
   input  wire logic        stall
);
   logic [15:0] rx_q[$];  // words taken, in arrival order
   initial isp_ready = 1'h0;
   // ready toggles while stalling, so the block must hold its word
   always @(posedge clk) begin
      if (isp_valid && isp_ready) rx_q.push_back(isp_data);
      isp_ready <= stall ? ~isp_ready : 1'h1;
   end
   // receiver side: decompand per segment, then undo the programmed ratio shift
   function automatic logic [16:0] relin(input logic [11:0] c, input logic [1:0] sel);
      logic [16:0] v;
      v = (c < 12'h400) ? 17'(c) :
          (c < 12'hA00) ? 17'(c - 12'h400) * 17'h2 + 17'h400 :
          (c < 12'hD80) ? 17'(c - 12'hA00) * 17'h20 + 17'h1000 :
                          17'(c - 12'hD80) * 17'h40 + 17'h8000;
      // 32x gains a bit on the way back, hence 17 bits
      case (sel)
         RATIO_4X:  relin = v >> 2;
         RATIO_8X:  relin = v >> 1;
         RATIO_16X: relin = v;
         default:   relin = v << 1;
      endcase
   endfunction : relin
endmodule : hdrc_isp_model

// *** verification/hdrc_top_bench.sv ***
// self-checking bench: axi4-lite tasks, pixel driver, isp model
// assumes: one clock; the isp model records every word it takes
`timescale 1ns/10ps
module hdrc_top_bench;
   import hdrc_pkg::*;
   logic        clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, pix_valid = 0, stall = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        pix_ready, isp_valid, isp_ready;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [11:0] long_exposure = 0, short_exposure = 0;
   logic [15:0] isp_data, exp_q[$];
   int          n_mismatch = 0, check_count = 0;
   hdrc_top i_dut (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pix_valid, .pix_ready,
      .long_exposure, .short_exposure, .isp_valid, .isp_ready, .isp_data);
   hdrc_isp_model i_isp (.clk, .isp_valid, .isp_ready, .isp_data, .stall);
   initial forever #2 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   // aw and w offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit ta = 0, tw = 0;
      @(posedge clk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'h7, a, d};
      while (!(ta && tw)) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin ta = 1; s_axi_awvalid <= 0; end
         if (s_axi_wvalid && s_axi_wready) begin tw = 1; s_axi_wvalid <= 0; end
      end
      while (!s_axi_bvalid) @(posedge clk);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clk); while (!s_axi_rvalid);
      {rdat, rs} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 0;
   endtask : rdr
   // one pair held until taken; expected word queued
   task automatic px(input logic [11:0] l, input logic [11:0] s, input logic [15:0] e);
      @(posedge clk);
      {pix_valid, long_exposure, short_exposure} <= {1'h1, l, s};
      do @(posedge clk); while (!pix_ready);
      pix_valid <= 0;
      exp_q.push_back(e);
   endtask : px
   task automatic drain();
      repeat (300) if (i_isp.rx_q.size() < exp_q.size()) @(posedge clk);
      foreach (exp_q[i]) chk("isp_data", exp_q[i], i_isp.rx_q[i]);
      exp_q.delete();
      i_isp.rx_q.delete();
   endtask : drain
   function automatic logic [15:0] cmp(input int v);
      return v < 1024 ? v : v < 4096 ? (v - 1024) / 2 + 1024 :
         v < 32768 ? (v - 4096) / 32 + 2560 : (v - 32768) / 64 + 3456;
   endfunction : cmp
   // relinearised value loses the bits that each segment's step drops
   function automatic logic [31:0] flr(input int v);
      return v < 1024 ? v : v < 4096 ? v & ~1 : v < 32768 ? v & ~31 : v & ~63;
   endfunction : flr
   task automatic t_regs();
      rdr(ADDR_CTRL);
      chk("ctrl", 32'h0000000A, rdat);
      rdr(ADDR_LIMITS);
      chk("limits", 32'h03B90200, rdat);
      wr(ADDR_FRAME_LEN, 32'h1000);
      wr(ADDR_COARSE, 32'h0600);
      rdr(ADDR_STATUS);
      chk("status", 32'h00010046, rdat);
      px(12'hFFF, 12'h100, 16'h15F0);
      drain();
      rdr(ADDR_LIMITS);
      chk("limits", 32'h04600600, rdat);
      wr(ADDR_COARSE, 32'h0);
      rdr(ADDR_LIMITS);
      chk("limits", 32'h04600008, rdat);
      wr(8'h20, 32'h0);
      chk("bresp", RESP_SLVERR, rs);
      rdr(8'h20);
      chk("rresp", RESP_SLVERR, rs);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_ratio();
      for (int r = 0; r < 4; r++) begin
         wr(ADDR_CTRL, 32'h2 | (r << 2));
         px(12'h123, 12'h010, r == 0 ? 16'h048C : r == 1 ? 16'h0246 : r == 2 ? 16'h0123 : 16'h0091);
         drain();
      end
      wr(ADDR_CTRL, 32'h0);
      px(12'hABC, 12'h123, 16'h0ABC);
      wr(ADDR_CTRL, 32'h400A);
      px(12'h200, 12'h000, 16'h0000);
      drain();
      rdr(ADDR_MOTION);
      chk("motion", 32'h1, rdat);
      $display("t_ratio done");
   endtask : t_ratio
   task automatic t_comp();
      logic [11:0] sv[8] = '{12'h03F, 12'h040, 12'h041, 12'h0FF, 12'h100, 12'h7FF, 12'h800, 12'hFFF};
      wr(ADDR_CTRL, 32'hB);
      stall <= 1;
      foreach (sv[i]) px(12'hFFF, sv[i], cmp(sv[i] * 16));
      repeat (300) if (i_isp.rx_q.size() < exp_q.size()) @(posedge clk);
      foreach (sv[i]) begin
         chk("relin", flr(sv[i] * 16), i_isp.relin(i_isp.rx_q[i], RATIO_16X));
      end
      drain();
      stall <= 0;
      $display("t_comp done");
   endtask : t_comp
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1;
      t_regs();
      t_ratio();
      t_comp();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
endmodule : hdrc_top_bench
